// ### logic/ftt_defs.svh
// Constants for the FIFO, transmit-length and test-control register block.
`ifndef FTT_DEFS_SVH
`define FTT_DEFS_SVH

// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define FTT_IDX_TEST_CONTROL    6'h1B
`define FTT_IDX_FIFO_STATUS     6'h1C
`define FTT_IDX_TX_LENGTH_UPPER 6'h1D
`define FTT_IDX_TX_LENGTH_LOWER 6'h1E
`define FTT_IDX_FIFO_DATA       6'h1F
`define FTT_IDX_CONTROL         6'h20
`define FTT_IDX_IRQ_STATUS      6'h21
`define FTT_IDX_IRQ_MASK        6'h22

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define FTT_TC_FAST_CODER_CLOCK 0
`define FTT_TC_DECODER_TEST     1
`define FTT_TC_IO_TEST_LO       2
`define FTT_TC_IO_TEST_HI       3
`define FTT_TC_RF_LEVEL_TEST    6
`define FTT_TC_WRITE_MASK       8'h4F
`define FTT_TC_TEST_MASK        8'h0E
`define FTT_FS_OVERFLOW         7
`define FTT_TXL_PARTIAL_FLAG    0
`define FTT_CTRL_STOP           0
`define FTT_IRQ_OVERFLOW        0
`define FTT_IRQ_TX_EOF          1
`define FTT_IRQ_TEST_EXIT       2
`define FTT_IRQ_COUNT           3

// ---------------------------------------------------------------------------
// Reset values and sizes
// ---------------------------------------------------------------------------
`define FTT_RST_TEST_CONTROL    8'h00
`define FTT_RST_TX_LENGTH       8'h00
`define FTT_RST_IRQ             3'h0
`define FTT_FIFO_DEPTH          127
`define FTT_CODER_CLOCK_KHZ     13560

`endif

// ### logic/ftt_pkg.sv
// Types shared by the FIFO, transmit-length and test-control block.
package ftt_pkg;

    typedef enum logic [0:0]
    {
        FTT_TEST_IDLE   = 1'b0,
        FTT_TEST_ACTIVE = 1'b1
    } ftt_test_state_t;

    typedef logic [7:0] ftt_byte_t;

endpackage

// ### logic/ftt_if.sv
// Interfaces joining the register core to its bus slave and its FIFO memory.
`timescale 1ns/1ps

interface ftt_reg_if;
    logic       wr_stb;
    logic       rd_stb;
    logic [5:0] index;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       hit;

    modport slave (output wr_stb, output rd_stb, output index, output wdata, input rdata, input hit);
    modport core  (input wr_stb, input rd_stb, input index, input wdata, output rdata, output hit);
endinterface

interface ftt_mem_if;
    logic       wr_en;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic [6:0] raddr;
    logic [7:0] q;

    modport mem  (input wr_en, input waddr, input wdata, input raddr, output q);
    modport core (output wr_en, output waddr, output wdata, output raddr, input q);
endinterface

// ### logic/ftt_mem.sv
// Byte storage for the FIFO with a registered, write-forwarded read port.
`timescale 1ns/1ps

module ftt_mem
#(
    parameter int DEPTH = 127
)
(
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    ftt_mem_if.mem    port
);
    logic [7:0] store [0:DEPTH-1];

    // The pointers are seven bits wide, which caps the depth.
    generate
        if (DEPTH < 2 || DEPTH > 128)
        begin : g_bad_depth
            $error("Memory depth must lie between 2 and 128");
        end
    endgenerate

    always_ff @(posedge mclk_in)
    begin
        if (port.wr_en)
        begin
            store[port.waddr] <= port.wdata;
        end
    end

    // Forwarding lets a byte pushed into an empty FIFO show at the head at once.
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            port.q <= 8'h00;
        end
        else if (port.wr_en && (port.waddr == port.raddr))
        begin
            port.q <= port.wdata;
        end
        else
        begin
            port.q <= store[port.raddr];
        end
    end
endmodule

// ### logic/ftt_apb.sv
// APB slave front end: one wait state, then a register strobe on completion.
`timescale 1ns/1ps

module ftt_apb
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    ftt_reg_if.slave               regs
);
    logic access;
    logic done;

    // Register decoding reads paddr bits seven to two, so narrower buses cannot work.
    generate
        if (ADDR_W < 8)
        begin : g_bad_addr
            $error("Address width must be at least 8 bits");
        end
    endgenerate

    assign access      = psel_in && penable_in;
    assign done        = access && pready_out;
    assign regs.index  = paddr_in[7:2];
    assign regs.wdata  = pwdata_in[7:0];
    assign regs.wr_stb = done && pwrite_in && regs.hit && (paddr_in[1:0] == 2'h0);
    assign regs.rd_stb = done && !pwrite_in && regs.hit && (paddr_in[1:0] == 2'h0);

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end
        else
        begin
            pready_out  <= access && !pready_out;
            pslverr_out <= access && !pready_out && (!regs.hit || (paddr_in[1:0] != 2'h0));
            if (access && !pready_out && !pwrite_in)
            begin
                prdata_out <= {24'h00_0000, regs.rdata};
            end
        end
    end
endmodule

// ### logic/ftt_top.sv
// Register core for the data FIFO, transmit length and test control.
// Function
// - Writing decoder or I/O test bits puts the device into test mode.
// - Test mode persists until a stop condition, reset or enable low, whatever else software writes.
// - The stop condition clears the decoder and both I/O test bits.
// - Test control resets to zero on reset and while enable is low.
// - Coder clock test bit selects the 13.56 MHz coder clock.
// - Pushing a byte into a full 127-byte FIFO sets the overflow flag.
// - FIFO status bits six to zero give the held byte count.
// - Upper length bits seven to four hold count bits eleven to eight.
// - Upper length bits three to zero hold count bits seven to four.
// - Upper length register clears on reset and while enable is low.
// - Upper length register clears when transmit end-of-frame has been sent.
// - Lower length holds count bits three to zero, same clearing events.
// - Lower bit zero flags a partial byte; bits three to one give its bits.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "ftt_defs.svh"

module ftt_top
    import ftt_pkg::*;
#(
    parameter int ADDR_W     = 8,
    parameter int FIFO_DEPTH = `FTT_FIFO_DEPTH
)
(
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    input  wire logic              en_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              tx_pop_in,
    input  wire logic              tx_eof_in,
    output logic      [7:0]        tx_data_out,
    output logic                   tx_data_valid_out,
    output logic                   test_mode_out,
    output logic                   decoder_test_out,
    output logic      [1:0]        io_test_out,
    output logic                   rf_level_test_out,
    output logic                   fast_coder_clock_out,
    output logic      [11:0]       tx_byte_count_out,
    output logic                   tx_partial_valid_out,
    output logic      [2:0]        tx_partial_bits_out,
    output logic                   irq_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    generate
        if (FIFO_DEPTH < 2 || FIFO_DEPTH > 127)
        begin : g_bad_depth
            $error("FIFO depth must lie between 2 and 127");
        end
        if (ADDR_W < 8)
        begin : g_bad_addr
            $error("Address width must be at least 8 bits");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx >= `FTT_IDX_TEST_CONTROL) && (idx <= `FTT_IDX_IRQ_MASK);
    endfunction

    function automatic logic [6:0] ptr_inc(input logic [6:0] ptr);
        ptr_inc = (ptr == 7'(FIFO_DEPTH - 1)) ? 7'h00 : ptr + 7'h01;
    endfunction

    function automatic logic hits(input logic stb, input logic [5:0] idx, input logic [5:0] want);
        hits = stb && (idx == want);
    endfunction

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    ftt_reg_if regs ();
    ftt_mem_if mport ();

    ftt_apb #(
        .ADDR_W (ADDR_W)
    ) u_apb (
        .mclk_in     (mclk_in),
        .rst_n_in    (rst_n_in),
        .psel_in     (psel_in),
        .penable_in  (penable_in),
        .pwrite_in   (pwrite_in),
        .paddr_in    (paddr_in),
        .pwdata_in   (pwdata_in),
        .prdata_out  (prdata_out),
        .pready_out  (pready_out),
        .pslverr_out (pslverr_out),
        .regs        (regs.slave)
    );

    ftt_mem #(
        .DEPTH (FIFO_DEPTH)
    ) u_mem (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .port     (mport.mem)
    );

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    ftt_test_state_t        test_state;
    ftt_byte_t              test_control;
    ftt_byte_t              tx_length_upper;
    ftt_byte_t              tx_length_lower;
    logic [6:0]             wr_ptr;
    logic [6:0]             rd_ptr;
    logic [6:0]             count;
    logic                   overflow;
    logic [`FTT_IRQ_COUNT-1:0] irq_status;
    logic [`FTT_IRQ_COUNT-1:0] irq_mask;
    logic [`FTT_IRQ_COUNT-1:0] next_irq_status;
    logic [`FTT_IRQ_COUNT-1:0] irq_event;

    logic       wr_test;
    logic       wr_upper;
    logic       wr_lower;
    logic       wr_data;
    logic       wr_ctrl;
    logic       rd_data;
    logic       stop;
    logic       full;
    logic       push;
    logic       pop;
    logic       overflow_event;
    logic       test_exit;
    logic [6:0] next_rd_ptr;
    logic [6:0] next_count;

    assign regs.hit = is_mapped(regs.index);
    assign wr_test  = hits(regs.wr_stb, regs.index, `FTT_IDX_TEST_CONTROL);
    assign wr_upper = hits(regs.wr_stb, regs.index, `FTT_IDX_TX_LENGTH_UPPER);
    assign wr_lower = hits(regs.wr_stb, regs.index, `FTT_IDX_TX_LENGTH_LOWER);
    assign wr_data  = hits(regs.wr_stb, regs.index, `FTT_IDX_FIFO_DATA);
    assign wr_ctrl  = hits(regs.wr_stb, regs.index, `FTT_IDX_CONTROL);
    assign rd_data  = hits(regs.rd_stb, regs.index, `FTT_IDX_FIFO_DATA);
    assign stop     = wr_ctrl && regs.wdata[`FTT_CTRL_STOP];

    // ------------------------------------------------------------------
    // Test control and test mode
    // ------------------------------------------------------------------
    // A stop in the same cycle as a test write wins, so a test entry never
    // survives the stop that was meant to end it.
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in || !en_in)
        begin
            test_control <= `FTT_RST_TEST_CONTROL;
        end
        else if (stop)
        begin
            test_control <= (wr_test ? (regs.wdata & `FTT_TC_WRITE_MASK) : test_control)
                            & ~`FTT_TC_TEST_MASK;
        end
        else if (wr_test)
        begin
            test_control <= regs.wdata & `FTT_TC_WRITE_MASK;
        end
    end

    assign test_exit = (test_state == FTT_TEST_ACTIVE) && stop;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in || !en_in)
        begin
            test_state <= FTT_TEST_IDLE;
        end
        else
        begin
            case (test_state)
                FTT_TEST_IDLE:
                begin
                    if (wr_test && !stop && ((regs.wdata & `FTT_TC_TEST_MASK) != 8'h00))
                    begin
                        test_state <= FTT_TEST_ACTIVE;
                    end
                end
                FTT_TEST_ACTIVE:
                begin
                    // Clearing the bits by a plain write does not leave test mode.
                    if (stop)
                    begin
                        test_state <= FTT_TEST_IDLE;
                    end
                end
                default:
                begin
                    test_state <= FTT_TEST_IDLE;
                end
            endcase
        end
    end

    assign test_mode_out        = (test_state == FTT_TEST_ACTIVE);
    assign decoder_test_out     = test_control[`FTT_TC_DECODER_TEST];
    assign io_test_out          = {test_control[`FTT_TC_IO_TEST_HI], test_control[`FTT_TC_IO_TEST_LO]};
    assign rf_level_test_out    = test_control[`FTT_TC_RF_LEVEL_TEST];
    assign fast_coder_clock_out = test_control[`FTT_TC_FAST_CODER_CLOCK];

    // ------------------------------------------------------------------
    // Transmit length
    // ------------------------------------------------------------------
    // End-of-frame beats a same-cycle write: the frame just sent owned it.
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in || !en_in)
        begin
            tx_length_upper <= `FTT_RST_TX_LENGTH;
            tx_length_lower <= `FTT_RST_TX_LENGTH;
        end
        else if (tx_eof_in)
        begin
            tx_length_upper <= `FTT_RST_TX_LENGTH;
            tx_length_lower <= `FTT_RST_TX_LENGTH;
        end
        else
        begin
            if (wr_upper)
            begin
                tx_length_upper <= regs.wdata;
            end
            if (wr_lower)
            begin
                tx_length_lower <= regs.wdata;
            end
        end
    end

    // The transmitter relies on the host having loaded both bytes before start.
    assign tx_byte_count_out    = {tx_length_upper, tx_length_lower[7:4]};
    assign tx_partial_valid_out = tx_length_lower[`FTT_TXL_PARTIAL_FLAG];
    assign tx_partial_bits_out  = tx_length_lower[3:1];

    // ------------------------------------------------------------------
    // FIFO pointers, count and overflow
    // ------------------------------------------------------------------
    assign full           = (count == 7'(FIFO_DEPTH));
    assign push           = wr_data && !full;
    assign overflow_event = wr_data && full;
    assign pop            = (tx_pop_in || rd_data) && (count != 7'h00);
    assign next_rd_ptr    = pop ? ptr_inc(rd_ptr) : rd_ptr;

    always_comb
    begin
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + 7'h01;
        end
        else if (pop && !push)
        begin
            next_count = count - 7'h01;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in || !en_in)
        begin
            wr_ptr            <= 7'h00;
            rd_ptr            <= 7'h00;
            count             <= 7'h00;
            tx_data_valid_out <= 1'b0;
        end
        else
        begin
            wr_ptr            <= push ? ptr_inc(wr_ptr) : wr_ptr;
            rd_ptr            <= next_rd_ptr;
            count             <= next_count;
            tx_data_valid_out <= (next_count != 7'h00);
        end
    end

    // The flag stays set until reset or enable low, so a lost byte is never hidden.
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in || !en_in)
        begin
            overflow <= 1'b0;
        end
        else if (overflow_event)
        begin
            overflow <= 1'b1;
        end
    end

    assign mport.wr_en = push;
    assign mport.waddr = wr_ptr;
    assign mport.wdata = regs.wdata;
    assign mport.raddr = next_rd_ptr;
    assign tx_data_out = mport.q;

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign irq_event[`FTT_IRQ_OVERFLOW]  = overflow_event;
    assign irq_event[`FTT_IRQ_TX_EOF]    = tx_eof_in;
    assign irq_event[`FTT_IRQ_TEST_EXIT] = test_exit;

    genvar gi;
    generate
        for (gi = 0; gi < `FTT_IRQ_COUNT; gi = gi + 1)
        begin : g_irq
            // A new event in the clearing cycle keeps its bit set.
            assign next_irq_status[gi] = irq_event[gi] ||
                (irq_status[gi] && !(hits(regs.wr_stb, regs.index, `FTT_IDX_IRQ_STATUS) && regs.wdata[gi]));
        end
    endgenerate

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            irq_status <= `FTT_RST_IRQ;
            irq_mask   <= `FTT_RST_IRQ;
            irq_out    <= 1'b0;
        end
        else
        begin
            irq_status <= next_irq_status;
            if (hits(regs.wr_stb, regs.index, `FTT_IDX_IRQ_MASK))
            begin
                irq_mask <= regs.wdata[`FTT_IRQ_COUNT-1:0];
            end
            irq_out <= |(next_irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb
    begin
        case (regs.index)
            `FTT_IDX_TEST_CONTROL:    regs.rdata = test_control;
            `FTT_IDX_FIFO_STATUS:     regs.rdata = {overflow, count};
            `FTT_IDX_TX_LENGTH_UPPER: regs.rdata = tx_length_upper;
            `FTT_IDX_TX_LENGTH_LOWER: regs.rdata = tx_length_lower;
            `FTT_IDX_FIFO_DATA:       regs.rdata = mport.q;
            `FTT_IDX_IRQ_STATUS:      regs.rdata = {5'h00, irq_status};
            `FTT_IDX_IRQ_MASK:        regs.rdata = {5'h00, irq_mask};
            default:                  regs.rdata = 8'h00;
        endcase
    end

endmodule

// ### bench/ftt_top_asserts.sv
// Concurrent checks on the ports of the FIFO, length and test-control block.
`timescale 1ns/1ps
module ftt_top_asserts
(
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    input wire logic        en_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic        tx_eof_in,
    input wire logic        test_mode_out,
    input wire logic        decoder_test_out,
    input wire logic [1:0]  io_test_out,
    input wire logic        fast_coder_clock_out,
    input wire logic [11:0] tx_byte_count_out,
    input wire logic        tx_partial_valid_out
);
    logic wdone;
    logic stop;
    assign wdone = psel_in & penable_in & pready_out & pwrite_in & en_in;
    assign stop  = wdone & (paddr_in == 8'h80) & pwdata_in[0];
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    AST_TEST_ENTRY: assert property (wdone && paddr_in == 8'h6C && pwdata_in[3:1] != 3'h0 |=> test_mode_out)
        else $error("test mode not entered");
    AST_TEST_HOLD: assert property (test_mode_out && en_in && !stop |=> test_mode_out)
        else $error("test mode left without stop");
    AST_STOP_CLEAR: assert property (stop |=> !test_mode_out && !decoder_test_out && io_test_out == 2'h0)
        else $error("stop did not clear test bits");
    AST_EN_CLEAR: assert property (!en_in |=> !test_mode_out && !fast_coder_clock_out && tx_byte_count_out == 12'h000)
        else $error("enable low did not clear");
    AST_EOF_CLEAR: assert property (tx_eof_in |=> tx_byte_count_out == 12'h000 && !tx_partial_valid_out)
        else $error("end of frame did not clear length");
    AST_FAST_CLOCK: assert property (wdone && paddr_in == 8'h6C |=> fast_coder_clock_out == $past(pwdata_in[0]))
        else $error("coder clock bit wrong");
    AST_UPPER_LEN: assert property (wdone && paddr_in == 8'h74 && !tx_eof_in |=> tx_byte_count_out[11:4] == $past(pwdata_in[7:0]))
        else $error("upper length wrong");
    AST_ONE_WAIT: assert property (psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out)
        else $error("ready not after one wait state");
endmodule

bind ftt_top ftt_top_asserts chk (.mclk_in, .rst_n_in, .en_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pready_out, .tx_eof_in, .test_mode_out, .decoder_test_out, .io_test_out, .fast_coder_clock_out,
    .tx_byte_count_out, .tx_partial_valid_out);

// ### bench/ftt_tx_model.sv
// Transmitter-side stand-in that removes head bytes and reports end of frame.
`timescale 1ns/1ps
module ftt_tx_model
(
    input  wire logic mclk_in,
    output logic      tx_pop_out,
    output logic      tx_eof_out
);
    initial
    begin
        tx_pop_out = 1'b0;
        tx_eof_out = 1'b0;
    end

    // One-cycle pulse; the caller has programmed both lengths before an end of frame.
    task automatic pulse(input logic eof);
        tx_pop_out <= !eof;
        tx_eof_out <= eof;
        @(posedge mclk_in);
        tx_pop_out <= 1'b0;
        tx_eof_out <= 1'b0;
        @(posedge mclk_in);
    endtask
endmodule

// ### bench/fifo_txlen_test_regs_bench.sv
// Self-checking bench for the FIFO, transmit-length and test-control block.
`timescale 1ns/1ps
module fifo_txlen_test_regs_bench;
    logic        mclk_in, rst_n_in, en_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [7:0]  paddr_in, tx_data_out;
    logic [31:0] pwdata_in, prdata_out, q;
    logic        tx_pop_in, tx_eof_in, tx_data_valid_out, test_mode_out, decoder_test_out, rf_level_test_out;
    logic        fast_coder_clock_out, tx_partial_valid_out, irq_out, err;
    logic [1:0]  io_test_out;
    logic [2:0]  tx_partial_bits_out;
    logic [11:0] tx_byte_count_out;
    logic [31:0] tbits [3] = '{32'h02, 32'h04, 32'h08};
    int          miscompares = 0;
    int          total_checks = 0;

    ftt_top uut (.mclk_in, .rst_n_in, .en_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .tx_pop_in, .tx_eof_in, .tx_data_out, .tx_data_valid_out,
        .test_mode_out, .decoder_test_out, .io_test_out, .rf_level_test_out, .fast_coder_clock_out,
        .tx_byte_count_out, .tx_partial_valid_out, .tx_partial_bits_out, .irq_out);
    ftt_tx_model model (.mclk_in, .tx_pop_out(tx_pop_in), .tx_eof_out(tx_eof_in));

    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    // ----------------------------------------------------------------------
    // Bus access and comparison
    // ----------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The idle cycle at the end keeps two transfers from driving psel in one time step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        // Only the watchdog ends a wait that never completes.
        do
        begin
            @(posedge mclk_in);
        end while (pready_out !== 1'b1);
        q = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #500000;
        miscompares++;
        complete_run;
    end

    initial
    begin
        {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        en_in = 1'b1;
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        rd(8'h6C, 32'h0);
        rd(8'h74, 32'h0);
        rd(8'h70, 32'h0);
        chk(err, 1'b0);
        // The test bits are set again before the stop so that the stop has something to clear.
        foreach (tbits[i])
        begin
            wr(8'h6C, tbits[i]);
            chk(test_mode_out, 1'b1);
            wr(8'h6C, 32'h41);
            chk(test_mode_out, 1'b1);
            chk(fast_coder_clock_out, 1'b1);
            wr(8'h6C, tbits[i] | 32'h41);
            chk({io_test_out, decoder_test_out, rf_level_test_out}, {tbits[i][3:1], 1'b1});
            wr(8'h80, 32'h1);
            chk(test_mode_out, 1'b0);
            rd(8'h6C, 32'h41);
        end
        for (int i = 0; i < 127; i++)
            wr(8'h7C, i);
        rd(8'h70, 32'h7F);
        chk(tx_data_valid_out, 1'b1);
        wr(8'h88, 32'h1);
        wr(8'h7C, 32'hEE);
        rd(8'h70, 32'hFF);
        chk(irq_out, 1'b1);
        rd(8'h84, 32'h5);
        wr(8'h84, 32'h5);
        repeat (2) @(posedge mclk_in);
        chk(irq_out, 1'b0);
        rd(8'h7C, 32'h0);
        chk(tx_data_out, 8'h01);
        model.pulse(1'b0);
        chk(tx_data_out, 8'h02);
        rd(8'h70, 32'hFD);
        wr(8'h74, 32'hA5);
        wr(8'h78, 32'h3B);
        chk(tx_byte_count_out, 12'hA53);
        chk(tx_partial_valid_out, 1'b1);
        chk(tx_partial_bits_out, 3'h5);
        model.pulse(1'b1);
        chk(tx_byte_count_out, 12'h000);
        rd(8'h78, 32'h0);
        rd(8'h84, 32'h2);
        wr(8'h6C, 32'h43);
        wr(8'h74, 32'h12);
        chk(test_mode_out, 1'b1);
        en_in <= 1'b0;
        @(posedge mclk_in);
        en_in <= 1'b1;
        @(posedge mclk_in);
        chk(test_mode_out, 1'b0);
        rd(8'h6C, 32'h0);
        rd(8'h74, 32'h0);
        rd(8'h70, 32'h0);
        chk(tx_data_valid_out, 1'b0);
        wr(8'h75, 32'hFF);
        chk(err, 1'b1);
        rd(8'h74, 32'h0);
        rd(8'hFC, 32'h0);
        chk(err, 1'b1);
        complete_run;
    end
endmodule
